//--- ubb_pkg.sv
// constants, register map and field layout of the billboard power/config block
package ubb_pkg;
  // =====================================================================
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int RESUME_DRIVE_MS = 10;
  localparam int RESUME_DRIVE_CYC = RESUME_DRIVE_MS * 1000000 / CLK_PERIOD_NS;
  // =====================================================================
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IDS = 8'h04;
  localparam logic [7:0] OFS_BCD = 8'h08;
  localparam logic [7:0] OFS_POWER = 8'h0c;
  localparam logic [7:0] OFS_ALT = 8'h10;
  localparam logic [7:0] OFS_GPIO_MODE = 8'h14;
  localparam logic [7:0] OFS_GPIO_OUT = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_STORE_ADDR = 8'h20;
  localparam logic [7:0] OFS_STORE_DATA = 8'h24;
  localparam logic [7:0] OFS_STR_CFG = 8'h28;
  // =====================================================================
  // control fields
  localparam int CTRL_RWU_EN = 0;
  localparam int CTRL_SELF_PWR = 1;
  localparam int CTRL_SUSP_HI = 2;
  localparam int CTRL_RES_HI = 3;
  localparam logic [3:0] CTRL_RST = 4'h5;
  // status fields
  localparam int STAT_SUSP = 0;
  localparam int STAT_RESUMING = 1;
  localparam int STAT_CONFIGURED = 2;
  localparam int STAT_HOST_RWU = 3;
  localparam int STAT_STR_OVF = 4;
  localparam int STAT_SERIAL_DIE = 5;
  // id, release, power and alternate mode fields
  localparam int IDS_PID_LSB = 16;
  localparam logic [15:0] BCD_RST = 16'h0000;
  localparam logic [9:0] MAX_MA_RST = 10'h064;
  localparam logic [9:0] MAX_MA_LIMIT = 10'h1f4;
  localparam int ALT_PREF_LSB = 8;
  localparam logic [3:0] ALT_NUM_RST = 4'h1;
  localparam logic [3:0] ALT_NUM_MAX = 4'h8;
  localparam logic [3:0] ALT_PREF_RST = 4'h0;
  localparam logic [3:0] ALT_PREF_MAX = 4'h7;
  // string space fields
  localparam int STR_TOTAL_LSB = 16;
  localparam logic [6:0] STR_LEN_MAX = 7'h7e;
  localparam logic [10:0] STR_SPACE = 11'h780;
  // =====================================================================
  // configuration store and pins
  localparam int STORE_BYTES = 2560;
  localparam int STORE_WORDS = STORE_BYTES / 4;
  localparam int GPIO_PINS = 13;
  localparam int PIN_WAKE = 0;
  localparam logic [1:0] GM_INPUT = 2'h0;
  localparam logic [1:0] GM_PWR_SW = 2'h1;
  localparam logic [1:0] GM_TRI = 2'h2;
  localparam logic [1:0] GM_OUT = 2'h3;
  localparam logic [25:0] GPIO_MODE_RST = 26'h29aaaa8;
  // suspend state machine
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b001,
    ST_SUSP = 3'b010,
    ST_RESUME = 3'b100
  } ubb_state_t;
endpackage

//--- ubb_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/100ps
module ubb_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

//--- ubb_ctrl.sv
// billboard device power, suspend, pin and configuration control
`timescale 1ns/100ps
module ubb_ctrl #(
  parameter int RESUME_CYC = ubb_pkg::RESUME_DRIVE_CYC,
  parameter int NPIN = ubb_pkg::GPIO_PINS,
  parameter logic [15:0] VID_DEF = 16'h1111, // arbitrary value
  parameter logic [15:0] PID_DEF = 16'h2222, // arbitrary value
  parameter logic [31:0] DIE_ID = 32'h0000_5a5a // arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic usb_idle_susp,
  input wire logic usb_bus_activity,
  input wire logic usb_configured,
  input wire logic usb_bus_reset,
  input wire logic usb_set_rwu,
  input wire logic usb_clr_rwu,
  output logic resume_k,
  output logic susp_pin,
  input wire logic resume_pin,
  input wire logic [NPIN-1:0] gpio_i,
  output logic [NPIN-1:0] gpio_o,
  output logic [NPIN-1:0] gpio_oe,
  output logic clk_slow_sel,
  output logic osc_fast_en,
  input wire logic desc_rd,
  input wire logic [11:0] desc_addr,
  output logic [7:0] desc_byte,
  output logic desc_valid,
  output logic [15:0] desc_vid,
  output logic [15:0] desc_pid,
  output logic [15:0] desc_bcd,
  output logic [7:0] desc_attr,
  output logic [7:0] desc_max_power,
  output logic [3:0] desc_num_alt,
  output logic [3:0] desc_pref_alt,
  output logic desc_bb_cap,
  output logic desc_serial_die,
  output logic [31:0] die_serial
);
  import ubb_pkg::*;
  localparam int CW = $clog2(RESUME_CYC + 1);

  // =====================================================================
  // pin synchronisers and reset merge
  logic [NPIN+1:0] sync_q;
  logic rst_i;
  logic [NPIN-1:0] gpio_s;
  logic resume_s;

  ubb_sync #(.W(NPIN + 2)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({chip_rst_n, resume_pin, gpio_i}),
    .q(sync_q)
  );
  // the chip reset pin joins power-on reset only after synchronising
  assign rst_i = rst | ~sync_q[NPIN+1];
  assign resume_s = sync_q[NPIN];
  assign gpio_s = sync_q[NPIN-1:0];

  // =====================================================================
  // configuration registers
  logic [3:0] ctrl_r;
  logic [15:0] vid_r;
  logic [15:0] pid_r;
  logic [15:0] bcd_r;
  logic [9:0] max_ma_r;
  logic [3:0] alt_num_r;
  logic [3:0] alt_pref_r;
  logic [2*NPIN-1:0] gmode_r;
  logic [NPIN-1:0] gout_r;
  logic [9:0] st_addr_r;
  logic [6:0] ser_len_r;
  logic [10:0] str_total_r;
  logic [31:0] mem [STORE_WORDS];
  logic wr_en;
  logic acc_en;

  // write takes effect at the edge where pready is sampled high
  assign acc_en = psel & penable & pready;
  assign wr_en = acc_en & pwrite;

  // control and descriptor fields, out-of-range writes are clamped or kept; a string total above the space is stored and flagged
  always_ff @(posedge clk) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
      vid_r <= VID_DEF;
      pid_r <= PID_DEF;
      bcd_r <= BCD_RST;
      max_ma_r <= MAX_MA_RST;
      alt_num_r <= ALT_NUM_RST;
      alt_pref_r <= ALT_PREF_RST;
      ser_len_r <= '0;
      str_total_r <= '0;
    end else if (wr_en) begin
      case (paddr)
        OFS_CTRL: ctrl_r <= pwdata[3:0];
        OFS_IDS: begin
          vid_r <= pwdata[15:0];
          pid_r <= pwdata[IDS_PID_LSB +: 16];
        end
        OFS_BCD: bcd_r <= pwdata[15:0];
        OFS_POWER: begin
          // anything above the limit is held at the limit
          if (pwdata[31:10] != '0 || pwdata[9:0] > MAX_MA_LIMIT) begin
            max_ma_r <= MAX_MA_LIMIT;
          end else begin
            max_ma_r <= pwdata[9:0];
          end
        end
        OFS_ALT: begin
          // illegal counts leave the previous value in place
          if (pwdata[3:0] != '0 && pwdata[3:0] <= ALT_NUM_MAX) begin
            alt_num_r <= pwdata[3:0];
          end
          if (pwdata[ALT_PREF_LSB +: 4] <= ALT_PREF_MAX) begin
            alt_pref_r <= pwdata[ALT_PREF_LSB +: 4];
          end
        end
        OFS_STR_CFG: begin
          ser_len_r <= (pwdata[6:0] > STR_LEN_MAX) ? STR_LEN_MAX : pwdata[6:0];
          str_total_r <= pwdata[STR_TOTAL_LSB +: 11];
        end
        default: begin
        end
      endcase
    end
  end

  // pin mode and output value registers
  always_ff @(posedge clk) begin
    if (rst_i) begin
      gmode_r <= GPIO_MODE_RST[2*NPIN-1:0];
      gout_r <= '1; // open-drain pins start released, not pulled low
    end else if (wr_en && paddr == OFS_GPIO_MODE) begin
      gmode_r <= pwdata[2*NPIN-1:0];
    end else if (wr_en && paddr == OFS_GPIO_OUT) begin
      gout_r <= pwdata[NPIN-1:0];
    end
  end

  // configuration store, word window with auto-increment
  always_ff @(posedge clk) begin
    if (rst_i) begin
      st_addr_r <= '0;
    end else if (wr_en && paddr == OFS_STORE_ADDR) begin
      st_addr_r <= pwdata[9:0];
    end else if (acc_en && paddr == OFS_STORE_DATA) begin
      st_addr_r <= st_addr_r + 10'h001;
    end
  end

  // store array has no reset; contents persist like the real store
  always_ff @(posedge clk) begin
    if (wr_en && paddr == OFS_STORE_DATA && st_addr_r < 10'(STORE_WORDS)) begin
      mem[st_addr_r] <= pwdata;
    end
  end

  // =====================================================================
  // suspend, resume and remote wakeup
  ubb_state_t state_r;
  logic host_rwu_r;
  logic [CW-1:0] k_cnt_r;
  logic res_act;
  logic wake_req;

  // polarity of the resume input is software selectable
  assign res_act = ctrl_r[CTRL_RES_HI] ? resume_s : ~resume_s;
  assign wake_req = ctrl_r[CTRL_RWU_EN] & (res_act |
    (gmode_r[2*PIN_WAKE +: 2] == GM_INPUT & gpio_s[PIN_WAKE]));

  // host feature flag; a set in the same cycle as a clear wins
  always_ff @(posedge clk) begin
    if (rst_i) begin
      host_rwu_r <= 1'b0;
    end else if (usb_set_rwu) begin
      host_rwu_r <= 1'b1;
    end else if (usb_clr_rwu || usb_bus_reset) begin
      host_rwu_r <= 1'b0;
    end
  end

  // bus activity has priority over a local wake request
  always_ff @(posedge clk) begin
    if (rst_i) begin
      state_r <= ST_ACTIVE;
      k_cnt_r <= '0;
    end else begin
      case (state_r)
        ST_ACTIVE: begin
          if (usb_idle_susp) begin
            state_r <= ST_SUSP;
          end
        end
        ST_SUSP: begin
          if (usb_bus_activity) begin
            state_r <= ST_ACTIVE;
          end else if (wake_req && host_rwu_r) begin
            state_r <= ST_RESUME;
            k_cnt_r <= CW'(RESUME_CYC - 1);
          end else if (wake_req) begin
            state_r <= ST_ACTIVE;
          end
        end
        ST_RESUME: begin
          // the k state is held for a fixed time, then the host takes over
          if (k_cnt_r == '0) begin
            state_r <= ST_ACTIVE;
          end else begin
            k_cnt_r <= k_cnt_r - CW'(1);
          end
        end
        default: state_r <= ST_ACTIVE;
      endcase
    end
  end

  // =====================================================================
  // suspend pins, clock source and power switch
  logic pwr_sw_r;
  logic susp_now;

  assign susp_now = (state_r == ST_SUSP);

  always_ff @(posedge clk) begin
    if (rst_i) begin
      susp_pin <= ~CTRL_RST[CTRL_SUSP_HI];
      resume_k <= 1'b0;
      clk_slow_sel <= 1'b0;
      osc_fast_en <= 1'b1;
      pwr_sw_r <= 1'b1;
    end else begin
      susp_pin <= ctrl_r[CTRL_SUSP_HI] ? susp_now : ~susp_now;
      resume_k <= (state_r == ST_RESUME);
      clk_slow_sel <= susp_now;
      osc_fast_en <= ~susp_now;
      pwr_sw_r <= ~usb_configured | susp_now;
    end
  end

  // per pin drive: open-drain pulls low only, power mode follows the switch
  always_ff @(posedge clk) begin
    if (rst_i) begin
      gpio_o <= '0;
      gpio_oe <= '0;
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        case (gmode_r[2*i +: 2])
          GM_PWR_SW: begin
            gpio_o[i] <= pwr_sw_r;
            gpio_oe[i] <= 1'b1;
          end
          GM_TRI: begin
            gpio_o[i] <= 1'b0;
            gpio_oe[i] <= ~gout_r[i];
          end
          GM_OUT: begin
            gpio_o[i] <= gout_r[i];
            gpio_oe[i] <= 1'b1;
          end
          default: begin
            gpio_o[i] <= 1'b0;
            gpio_oe[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  // =====================================================================
  // descriptor fields for the enumeration engine
  always_ff @(posedge clk) begin
    if (rst_i) begin
      desc_vid <= VID_DEF;
      desc_pid <= PID_DEF;
      desc_bcd <= BCD_RST;
      desc_attr <= 8'h80;
      desc_max_power <= 8'h00;
      desc_num_alt <= ALT_NUM_RST;
      desc_pref_alt <= ALT_PREF_RST;
      desc_bb_cap <= 1'b0;
      desc_serial_die <= 1'b1;
      die_serial <= '0;
    end else begin
      desc_vid <= vid_r;
      desc_pid <= pid_r;
      desc_bcd <= bcd_r;
      desc_attr <= {1'b1, ctrl_r[CTRL_SELF_PWR], ctrl_r[CTRL_RWU_EN], 5'h00};
      desc_max_power <= max_ma_r[8:1];
      desc_num_alt <= alt_num_r;
      desc_pref_alt <= alt_pref_r;
      desc_bb_cap <= 1'b1;
      desc_serial_die <= (ser_len_r == '0);
      die_serial <= DIE_ID;
    end
  end

  // byte reads of the store for BOS and string descriptors, one cycle
  always_ff @(posedge clk) begin
    if (rst_i) begin
      desc_byte <= '0;
      desc_valid <= 1'b0;
    end else begin
      desc_valid <= desc_rd;
      if (desc_rd && desc_addr < 12'(STORE_BYTES)) begin
        desc_byte <= mem[desc_addr[11:2]][8*desc_addr[1:0] +: 8];
      end else if (desc_rd) begin
        desc_byte <= '0;
      end
    end
  end

  // =====================================================================
  // apb slave: zero wait states, unmapped offsets answer with pslverr
  always_ff @(posedge clk) begin
    if (rst_i) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= '0;
        case (paddr)
          OFS_CTRL: prdata[3:0] <= ctrl_r;
          OFS_IDS: prdata <= {pid_r, vid_r};
          OFS_BCD: prdata[15:0] <= bcd_r;
          OFS_POWER: prdata[9:0] <= max_ma_r;
          OFS_ALT: prdata[11:0] <= {alt_pref_r, 4'h0, alt_num_r};
          OFS_GPIO_MODE: prdata[2*NPIN-1:0] <= gmode_r;
          OFS_GPIO_OUT: prdata[NPIN-1:0] <= gpio_s;
          OFS_STATUS: begin
            prdata[STAT_SUSP] <= susp_now;
            prdata[STAT_RESUMING] <= (state_r == ST_RESUME);
            prdata[STAT_CONFIGURED] <= usb_configured;
            prdata[STAT_HOST_RWU] <= host_rwu_r;
            prdata[STAT_STR_OVF] <= (str_total_r > STR_SPACE);
            prdata[STAT_SERIAL_DIE] <= (ser_len_r == '0);
          end
          OFS_STORE_ADDR: prdata[9:0] <= st_addr_r;
          OFS_STORE_DATA: prdata <= (st_addr_r < 10'(STORE_WORDS)) ? mem[st_addr_r] : '0;
          OFS_STR_CFG: prdata <= {5'h00, str_total_r, 9'h000, ser_len_r};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // =====================================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst_i);

  sequence s_susp_wake(logic feat);
    state_r == ST_SUSP && !usb_bus_activity && wake_req && host_rwu_r == feat;
  endsequence

  chk_susp_pin_level: assert property (
    susp_now ##1 susp_now |-> susp_pin == ctrl_r[CTRL_SUSP_HI]
  ) else $error("suspend indicator wrong while suspended");
  chk_activity_exit: assert property (
    state_r == ST_SUSP && usb_bus_activity |=> state_r == ST_ACTIVE
  ) else $error("bus activity did not end suspend");
  chk_wake_signals: assert property (
    s_susp_wake(1'b1) |=> state_r == ST_RESUME ##1 resume_k
  ) else $error("enabled wakeup did not drive resume");
  chk_no_k_unarmed: assert property (
    s_susp_wake(1'b0) |=> state_r == ST_ACTIVE ##1 !resume_k
  ) else $error("resume driven without host feature");
  chk_pwr_switch: assert property (
    (state_r == ST_ACTIVE && usb_configured) [*3] |-> !pwr_sw_r
  ) else $error("power switch not on while configured");
  chk_max_current_cap: assert property (
    wr_en && paddr == OFS_POWER && pwdata[9:0] > MAX_MA_LIMIT |=> max_ma_r == MAX_MA_LIMIT
  ) else $error("max current not clamped");
  chk_alt_range: assert property (
    desc_num_alt >= 4'h1 && desc_num_alt <= ALT_NUM_MAX && desc_pref_alt <= ALT_PREF_MAX
  ) else $error("alternate mode field out of range");
  chk_slow_clock: assert property (
    susp_now [*2] |-> clk_slow_sel && !osc_fast_en
  ) else $error("slow clock not selected in suspend");
  chk_chip_reset: assert property (@(posedge clk) disable iff (rst)
    !sync_q[NPIN+1] |=> state_r == ST_ACTIVE && ctrl_r == CTRL_RST
  ) else $error("chip reset did not restore defaults");
endmodule

//--- ubb_far_model.sv
// far-side model: usb host events and board logic around the block
`timescale 1ns/100ps
module ubb_far_model (
  input wire logic clk,
  input wire logic [ubb_pkg::GPIO_PINS-1:0] gpio_o,
  input wire logic [ubb_pkg::GPIO_PINS-1:0] gpio_oe,
  output logic usb_idle_susp,
  output logic usb_bus_activity,
  output logic usb_configured,
  output logic usb_bus_reset,
  output logic usb_set_rwu,
  output logic usb_clr_rwu,
  output logic resume_pin,
  output logic chip_rst_n,
  output logic [ubb_pkg::GPIO_PINS-1:0] gpio_i
);
  import ubb_pkg::*;
  logic [GPIO_PINS-1:0] board;
  // ===================================================================
  // pin levels
  // a driven pin shows the device level, a released one the board level
  assign gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & board);
  // idle board: resume pin at its inactive default level
  initial begin
    usb_idle_susp = 1'b0;
    usb_bus_activity = 1'b0;
    usb_configured = 1'b0;
    usb_bus_reset = 1'b0;
    usb_set_rwu = 1'b0;
    usb_clr_rwu = 1'b0;
    resume_pin = 1'b1;
    chip_rst_n = 1'b1;
    board = '0;
  end
  // ===================================================================
  // host and board actions, launched just after an edge
  // one-cycle event: 0 idle, 1 activity, 2 set feature, 3 clear feature, 4 bus reset
  task automatic sie_pulse(input int k);
    @(posedge clk);
    usb_idle_susp <= (k == 0);
    usb_bus_activity <= (k == 1);
    usb_set_rwu <= (k == 2);
    usb_clr_rwu <= (k == 3);
    usb_bus_reset <= (k == 4);
    @(posedge clk);
    usb_bus_reset <= 1'b0;
    usb_idle_susp <= 1'b0;
    usb_bus_activity <= 1'b0;
    usb_set_rwu <= 1'b0;
    usb_clr_rwu <= 1'b0;
  endtask
  // raw level on the resume pin; board logic asserts it in suspend
  task automatic resume_lvl(input logic v);
    @(posedge clk);
    resume_pin <= v;
  endtask
  task automatic wake_lvl(input logic v);
    @(posedge clk);
    board[PIN_WAKE] <= v;
  endtask
  task automatic set_cfg(input logic v);
    @(posedge clk);
    usb_configured <= v;
  endtask
  // held low long enough to pass the pin synchroniser
  task automatic chip_reset();
    @(posedge clk);
    chip_rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    chip_rst_n <= 1'b1;
  endtask
endmodule

//--- tb_top.sv
// self-checking bench for the billboard power and configuration block
`timescale 1ns/100ps
module tb_top;
  import ubb_pkg::*;
  localparam int RCYC = 20;
  localparam logic [31:0] DIE = 32'h0000_c3a5; // arbitrary value
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err, seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, die_serial;
  logic usb_idle_susp, usb_bus_activity, usb_configured, usb_bus_reset, usb_set_rwu;
  logic usb_clr_rwu, resume_k, susp_pin, resume_pin, chip_rst_n, clk_slow_sel, osc_fast_en;
  logic [GPIO_PINS-1:0] gpio_i, gpio_o, gpio_oe;
  logic desc_rd, desc_valid, desc_bb_cap, desc_serial_die;
  logic [11:0] desc_addr;
  logic [7:0] desc_byte, desc_attr, desc_max_power;
  logic [15:0] desc_vid, desc_pid, desc_bcd;
  logic [3:0] desc_num_alt, desc_pref_alt;
  int n_mismatch, total_checks, n;
  // ===================================================================
  // design and far side
  ubb_ctrl #(.RESUME_CYC(RCYC), .DIE_ID(DIE)) dut (.clk, .rst, .chip_rst_n, .psel,
    .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .usb_idle_susp, .usb_bus_activity,
    .usb_configured, .usb_bus_reset, .usb_set_rwu, .usb_clr_rwu, .resume_k, .susp_pin,
    .resume_pin, .gpio_i, .gpio_o, .gpio_oe, .clk_slow_sel, .osc_fast_en, .desc_rd,
    .desc_addr, .desc_byte, .desc_valid, .desc_vid, .desc_pid, .desc_bcd, .desc_attr,
    .desc_max_power, .desc_num_alt, .desc_pref_alt, .desc_bb_cap, .desc_serial_die,
    .die_serial);
  ubb_far_model far (.clk, .gpio_o, .gpio_oe, .usb_idle_susp, .usb_bus_activity,
    .usb_configured, .usb_bus_reset, .usb_set_rwu, .usb_clr_rwu, .resume_pin,
    .chip_rst_n, .gpio_i);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ===================================================================
  // helpers
  task automatic end_sim();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic hang();
    n_mismatch++;
    end_sim();
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) hang();
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // two spare edges let the descriptor copies follow
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (2) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_for(ref logic s, input logic v);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (s !== v && k < 40);
    if (s !== v) hang();
  endtask
  task automatic desc_get(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk);
    desc_rd <= 1'b1;
    desc_addr <= a;
    @(posedge clk);
    desc_rd <= 1'b0;
    #1;
    chk("desc_byte", {1'b1, exp}, {desc_valid, desc_byte});
  endtask
  task automatic suspend_now(input logic lvl);
    far.sie_pulse(0);
    wait_for(susp_pin, lvl);
  endtask
  // ===================================================================
  // scenarios
  task automatic t_defaults();
    rd(OFS_CTRL);
    chk("ctrl", {28'h0, CTRL_RST}, q);
    rd(OFS_POWER);
    chk("power", 32'd100, q);
    rd(OFS_ALT);
    chk("alt", 32'h1, q);
    rd(OFS_BCD);
    chk("bcd", 32'h0, q);
    chk("max_power", 8'd50, desc_max_power);
    chk("attr", 8'ha0, desc_attr);
    chk("ids", 32'h2222_1111, {desc_pid, desc_vid});
    chk("flags", 2'b11, {desc_bb_cap, desc_serial_die});
    chk("pins", 5'b10100, {gpio_oe[10], gpio_oe[PIN_WAKE], gpio_o[10], gpio_oe[2], gpio_oe[3]});
    chk("die_serial", DIE, die_serial);
    chk("osc", 2'b01, {clk_slow_sel, osc_fast_en});
  endtask
  task automatic t_config();
    wr(OFS_POWER, 32'd600);
    rd(OFS_POWER);
    chk("power_clamp", {22'h0, MAX_MA_LIMIT}, q);
    chk("max_power_clamp", 8'd250, desc_max_power);
    wr(OFS_ALT, 32'h0708);
    wr(OFS_ALT, 32'h0800);
    rd(OFS_ALT);
    chk("alt_keep", 32'h0708, q);
    chk("alt_desc", 8'h78, {desc_pref_alt, desc_num_alt});
    wr(OFS_BCD, 32'h1234);
    wr(OFS_IDS, 32'h3333_4444);
    chk("bcd_desc", 16'h1234, desc_bcd);
    chk("ids_desc", 32'h3333_4444, {desc_pid, desc_vid});
    wr(OFS_CTRL, 32'h6);
    chk("attr_self", 8'hc0, desc_attr);
    wr(OFS_CTRL, {28'h0, CTRL_RST});
    apb(1'b0, 8'h2c, 32'h0);
    chk("unmapped", 2'b10, {err, |q});
  endtask
  task automatic t_store();
    wr(OFS_STORE_ADDR, 32'h0);
    wr(OFS_STORE_DATA, 32'h4433_2211);
    wr(OFS_STORE_DATA, 32'h8877_6655);
    for (int i = 0; i < 8; i++) begin
      desc_get(12'(i), 8'(8'h11 * (i + 1)));
    end
    wr(OFS_STORE_ADDR, STORE_WORDS - 1);
    wr(OFS_STORE_DATA, 32'ha5c3_0000);
    desc_get(12'(STORE_BYTES - 1), 8'ha5);
    desc_get(12'(STORE_BYTES), 8'h00);
    wr(OFS_STR_CFG, 32'h07d0_007f);
    rd(OFS_STR_CFG);
    chk("serial_len", 32'h07d0_007e, q);
    chk("serial_die_off", 1'b0, desc_serial_die);
    rd(OFS_STATUS);
    chk("str_ovf", 1'b1, q[STAT_STR_OVF]);
    wr(OFS_STR_CFG, {5'h0, STR_SPACE, 16'h0});
    rd(OFS_STATUS);
    chk("str_fit", 2'b10, {q[STAT_SERIAL_DIE], q[STAT_STR_OVF]});
  endtask
  // pin 1 driven output, pin 2 power switch, pin 3 open drain
  task automatic t_gpio();
    wr(OFS_GPIO_MODE, 32'h029a_aa9c);
    wr(OFS_GPIO_OUT, 32'h000a);
    chk("pin_hi", 5'b11110, {gpio_o[1], gpio_oe[1], gpio_oe[2], gpio_o[2], gpio_oe[3]});
    wr(OFS_GPIO_OUT, 32'h0);
    chk("pin_lo", 3'b010, {gpio_o[1], gpio_oe[3], gpio_o[3]});
    far.wake_lvl(1'b1);
    repeat (4) @(posedge clk);
    rd(OFS_GPIO_OUT);
    chk("pin_in", 1'b1, q[PIN_WAKE]);
    far.wake_lvl(1'b0);
    wr(OFS_GPIO_MODE, {6'h0, GPIO_MODE_RST});
  endtask
  task automatic t_suspend();
    far.set_cfg(1'b1);
    repeat (4) @(posedge clk);
    chk("pwr_cfg", 1'b0, gpio_o[10]);
    suspend_now(1'b1);
    repeat (3) @(posedge clk);
    chk("susp", 4'b1101, {susp_pin, clk_slow_sel, osc_fast_en, gpio_o[10]});
    rd(OFS_STATUS);
    chk("status", 4'b0101, q[3:0]);
    far.sie_pulse(1);
    wait_for(susp_pin, 1'b0);
    repeat (2) @(posedge clk);
    chk("awake", 4'b0010, {resume_k, clk_slow_sel, osc_fast_en, gpio_o[10]});
  endtask
  task automatic t_rwu();
    far.sie_pulse(2);
    suspend_now(1'b1);
    far.resume_lvl(1'b0);
    wait_for(resume_k, 1'b1);
    chk("k_susp", 1'b0, susp_pin);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (resume_k === 1'b1 && n < 100);
    chk("k_len", RCYC, n);
    far.resume_lvl(1'b1);
  endtask
  task automatic t_no_feature();
    far.sie_pulse(3);
    rd(OFS_STATUS);
    chk("rwu_clr", 1'b0, q[STAT_HOST_RWU]);
    far.sie_pulse(2);
    far.sie_pulse(4);
    suspend_now(1'b1);
    far.wake_lvl(1'b1);
    seen = 1'b0;
    repeat (12) begin
      @(posedge clk);
      #1;
      seen |= resume_k;
    end
    far.wake_lvl(1'b0);
    chk("no_k", 2'b00, {seen, susp_pin});
  endtask
  task automatic t_rwu_off();
    wr(OFS_CTRL, 32'h4);
    far.sie_pulse(2);
    suspend_now(1'b1);
    far.resume_lvl(1'b0);
    repeat (12) @(posedge clk);
    chk("rwu_off", 2'b10, {susp_pin, resume_k});
    far.resume_lvl(1'b1);
    far.sie_pulse(1);
    wr(OFS_CTRL, {28'h0, CTRL_RST});
  endtask
  task automatic t_polarity();
    far.resume_lvl(1'b0);
    wr(OFS_CTRL, 32'h9);
    chk("susp_idle", 1'b1, susp_pin);
    suspend_now(1'b0);
    far.resume_lvl(1'b1);
    wait_for(resume_k, 1'b1);
    chk("k_pol", 1'b1, susp_pin);
    far.resume_lvl(1'b0);
    wait_for(resume_k, 1'b0);
    wr(OFS_CTRL, {28'h0, CTRL_RST});
    far.resume_lvl(1'b1);
  endtask
  task automatic t_chip_rst();
    wr(OFS_POWER, 32'd300);
    far.chip_reset();
    repeat (6) @(posedge clk);
    rd(OFS_POWER);
    chk("chip_rst", 32'd100, q);
  endtask
  // ===================================================================
  // main sequence and hang guard
  initial begin
    n_mismatch = 0;
    total_checks = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    desc_rd = 1'b0;
    desc_addr = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_defaults();
    t_config();
    t_store();
    t_gpio();
    t_suspend();
    t_rwu();
    t_no_feature();
    t_rwu_off();
    t_polarity();
    t_chip_rst();
    end_sim();
  end
  initial begin
    repeat (100000) @(posedge clk);
    hang();
  end
endmodule
